// ### design/fault_flags_pkg.sv
// Constants shared by the gate driver fault flag register logic
package fault_flags_pkg;

  // Register access port
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 32;
  localparam logic [6:0] FLAGS_ADDR = 7'h01;

  // Flag register layout
  localparam int unsigned FLAGS_W = 15;
  localparam int unsigned PHASES = 3;
  localparam int unsigned RESET_BIT = 0;
  localparam int unsigned PREWARN_BIT = 1;
  localparam int unsigned OVERTEMP_BIT = 2;
  localparam int unsigned UNDERVOLT_BIT = 3;
  localparam int unsigned SHORT_COUNT_BASE = 4;
  localparam int unsigned GROUND_SHORT_BASE = 5;
  localparam int unsigned SUPPLY_SHORT_BASE = 6;
  localparam int unsigned PHASE_STRIDE = 4;

  // Reset value, implemented bits, bits kept over an enable cycle, fault bits
  localparam logic [14:0] FLAGS_RESET = 15'h0001;
  localparam logic [14:0] FLAGS_VALID = 15'h777f;
  localparam logic [14:0] FLAGS_KEEP_ON_CYCLE = 15'h0003;
  localparam logic [14:0] FLAGS_FAULT_MASK = 15'h777c;
  localparam logic [16:0] READ_PAD = 17'h00000;

  // Pin synchroniser width: enable, 3 levels, 3 x 3 phase events, 2 x 3 inputs
  localparam int unsigned SYNC_W = 19;

  // Bit position of a per-phase flag
  function automatic int unsigned phase_bit(input int unsigned base, input int unsigned phase);
    phase_bit = base + PHASE_STRIDE * phase;
  endfunction

endpackage

// ### design/pin_sync3.sv
// Three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             ref_clk_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] level_o
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } sync_state_t;

  sync_state_t q;
  sync_state_t d;

  always_comb begin
    d    = q;
    d.s1 = async_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // Take a change only once the second and third stages agree
    for (int i = 0; i < int'(WIDTH); i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.level[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level_o = q.level;

endmodule

// ### design/enable_cycle_detect.sv
// Detects a low-high cycle of the filtered driver enable level
`timescale 1ns/1ps
module enable_cycle_detect (
  input  wire logic ref_clk_i,
  input  wire logic nrst_i,
  input  wire logic enable_i,
  output logic      cycle_o
);

  typedef struct packed {
    logic seen_low;
    logic prev;
    logic cycle;
  } cycle_state_t;

  cycle_state_t q;
  cycle_state_t d;

  always_comb begin
    d       = q;
    d.prev  = enable_i;
    d.cycle = 1'b0;
    if (!enable_i) begin
      d.seen_low = 1'b1;
    end else if (q.seen_low && !q.prev) begin
      d.cycle    = 1'b1;
      d.seen_low = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cycle_o = q.cycle;

endmodule

// ### design/gate_driver_fault_status_flags.sv
// Global fault flag register of a three-phase gate driver
// Function
// RULE1: Writing one to a flag bit clears that flag.
// RULE2: Enable pin low-high cycle clears all flags except reset and prewarning.
// RULE3: Host must switch transistor off; clearing a flag never re-enables it.
// RULE4: After reset, reset flag reads one and registers hold reset values.
// RULE5: Reset flag clears only while driver enable pin is high.
// RULE6: Bit 1 latches on temperature prewarning; no protective action follows.
// RULE7: Bit 2 latches on overtemperature; clearing ignored while condition persists.
// RULE8: Bit 3 latches on pump undervoltage; gates off during undervoltage.
// RULE9: Bits 4, 8, 12 latch when phase U, V, W short counters trigger.
// RULE10: Bits 5, 9, 13 latch ground shorts; phase stays off until cleared.
// RULE11: Bits 6, 10 latch supply shorts; phase stays off until cleared.
// RULE12: Bit 14 latches phase W supply short; stays off until cleared.
// RULE13: Fault output is OR of overtemperature, undervoltage and short flags.
// RULE14: Writing zero leaves flags unchanged; bits 7 and 11 read zero.
// RULE15: A set event in the clearing cycle wins; flag stays one.
`timescale 1ns/1ps
module gate_driver_fault_status_flags (
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  // Register access from the serial interface decoder
  input  wire logic [6:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  output logic             reg_rvalid_o,
  // Driver enable pin
  input  wire logic        drv_en_i,
  // Detection circuit levels
  input  wire logic        prewarn_i,
  input  wire logic        overtemp_i,
  input  wire logic        pump_uv_i,
  input  wire logic [2:0]  short_count_i,
  input  wire logic [2:0]  ground_short_i,
  input  wire logic [2:0]  supply_short_i,
  // Control inputs, one per phase
  input  wire logic [2:0]  high_side_input_i,
  input  wire logic [2:0]  low_side_input_i,
  // Gate commands and fault status
  output logic      [2:0]  high_side_gate_o,
  output logic      [2:0]  low_side_gate_o,
  output logic             fault_status_o
);

  typedef struct packed {
    logic [14:0] flags;
    logic [2:0]  lock;
    logic [31:0] rdata;
    logic        rvalid;
    logic [2:0]  hs_gate;
    logic [2:0]  ls_gate;
    logic        fault;
  } flag_state_t;

  localparam flag_state_t STATE_RESET = '{
    flags:   fault_flags_pkg::FLAGS_RESET,
    lock:    3'h0,
    rdata:   32'h00000000,
    rvalid:  1'b0,
    hs_gate: 3'h0,
    ls_gate: 3'h0,
    fault:   1'b0
  };

  flag_state_t q;
  flag_state_t d;

  logic [fault_flags_pkg::SYNC_W-1:0] pins_s;
  logic                               drv_en_s;
  logic                               prewarn_s;
  logic                               overtemp_s;
  logic                               pump_uv_s;
  logic [2:0]                         short_count_s;
  logic [2:0]                         ground_short_s;
  logic [2:0]                         supply_short_s;
  logic [2:0]                         hs_in_s;
  logic [2:0]                         ls_in_s;
  logic                               en_cycle;

  // All pins come from outside the clock domain
  pin_sync3 #(
    .WIDTH (fault_flags_pkg::SYNC_W)
  ) u_pin_sync (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .async_i   ({drv_en_i, prewarn_i, overtemp_i, pump_uv_i, short_count_i,
                 ground_short_i, supply_short_i, high_side_input_i,
                 low_side_input_i}),
    .level_o   (pins_s)
  );

  assign {drv_en_s, prewarn_s, overtemp_s, pump_uv_s, short_count_s,
          ground_short_s, supply_short_s, hs_in_s, ls_in_s} = pins_s;

  enable_cycle_detect u_cycle (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .enable_i  (drv_en_s),
    .cycle_o   (en_cycle)
  );

  logic [14:0] set_vec;
  logic [14:0] clr_vec;
  logic        flags_hit;
  logic        phase_off;
  logic        phase_en;
  int unsigned gnd_pos;
  int unsigned sup_pos;

  always_comb begin
    d         = q;
    set_vec   = 15'h0000;
    clr_vec   = 15'h0000;
    flags_hit = (reg_addr_i == fault_flags_pkg::FLAGS_ADDR);
    phase_off = 1'b0;
    phase_en  = 1'b0;
    gnd_pos   = 0;
    sup_pos   = 0;

    // Set events
    set_vec[fault_flags_pkg::PREWARN_BIT]   = prewarn_s; // RULE6
    set_vec[fault_flags_pkg::OVERTEMP_BIT]  = overtemp_s; // RULE7
    set_vec[fault_flags_pkg::UNDERVOLT_BIT] = pump_uv_s; // RULE8
    for (int unsigned p = 0; p < fault_flags_pkg::PHASES; p++) begin
      set_vec[fault_flags_pkg::phase_bit(fault_flags_pkg::SHORT_COUNT_BASE, p)] =
        short_count_s[p]; // RULE9
      set_vec[fault_flags_pkg::phase_bit(fault_flags_pkg::GROUND_SHORT_BASE, p)] =
        ground_short_s[p]; // RULE10
      set_vec[fault_flags_pkg::phase_bit(fault_flags_pkg::SUPPLY_SHORT_BASE, p)] =
        supply_short_s[p]; // RULE11 RULE12
    end

    // Write-one-to-clear; zero bits and unimplemented bits are untouched
    if (reg_wr_i && flags_hit) begin
      clr_vec = reg_wdata_i[14:0] & fault_flags_pkg::FLAGS_VALID; // RULE1 RULE14
    end
    if (!drv_en_s) begin
      clr_vec[fault_flags_pkg::RESET_BIT] = 1'b0; // RULE5
    end
    if (overtemp_s) begin
      clr_vec[fault_flags_pkg::OVERTEMP_BIT] = 1'b0; // RULE7
    end

    // Enable cycle clears all but reset and prewarning
    if (en_cycle) begin
      clr_vec = clr_vec | (fault_flags_pkg::FLAGS_VALID &
                           ~fault_flags_pkg::FLAGS_KEEP_ON_CYCLE); // RULE2
    end

    // Set wins over a clear in the same cycle
    d.flags = ((q.flags & ~clr_vec) | set_vec) & fault_flags_pkg::FLAGS_VALID; // RULE15 RULE14

    // Per-phase shutdown from short flags
    for (int unsigned p = 0; p < fault_flags_pkg::PHASES; p++) begin
      gnd_pos   = fault_flags_pkg::phase_bit(fault_flags_pkg::GROUND_SHORT_BASE, p);
      sup_pos   = fault_flags_pkg::phase_bit(fault_flags_pkg::SUPPLY_SHORT_BASE, p);
      phase_off = d.flags[gnd_pos] | d.flags[sup_pos];
      // Lock releases only once both inputs of the phase are off
      if (phase_off) begin
        d.lock[p] = 1'b1; // RULE10 RULE11 RULE12
      end else if (!hs_in_s[p] && !ls_in_s[p]) begin
        d.lock[p] = 1'b0; // RULE3
      end
      phase_en = drv_en_s & ~pump_uv_s & ~overtemp_s & ~phase_off & ~q.lock[p]; // RULE8
      d.hs_gate[p] = hs_in_s[p] & phase_en;
      d.ls_gate[p] = ls_in_s[p] & phase_en;
    end

    d.fault = |(d.flags & fault_flags_pkg::FLAGS_FAULT_MASK); // RULE13

    // Read port; unmapped addresses return zero
    d.rvalid = reg_rd_i;
    d.rdata  = 32'h00000000;
    if (reg_rd_i && flags_hit) begin
      d.rdata = {fault_flags_pkg::READ_PAD, q.flags}; // RULE14
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      q <= STATE_RESET; // RULE4
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o      = q.rdata;
  assign reg_rvalid_o     = q.rvalid;
  assign high_side_gate_o = q.hs_gate;
  assign low_side_gate_o  = q.ls_gate;
  assign fault_status_o   = q.fault;

endmodule

// ### verification/flags_asserts.sv
// Port checker for the fault flag register
`timescale 1ns/1ps
module flags_asserts (
  input wire logic        ref_clk_i,
  input wire logic        nrst_i,
  input wire logic [6:0]  reg_addr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        reg_rvalid_o,
  input wire logic        overtemp_i,
  input wire logic        pump_uv_i,
  input wire logic [2:0]  high_side_gate_o,
  input wire logic [2:0]  low_side_gate_o,
  input wire logic        fault_status_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  wire off = (high_side_gate_o | low_side_gate_o) == 3'h0;
  rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o) else $error("no answer");
  rd_idle_a: assert property (!reg_rd_i |=> !reg_rvalid_o) else $error("stray valid");
  spare_zero_a: assert property (reg_rvalid_o |-> (reg_rdata_o & 32'hffff8880) == 0)
    else $error("spare bits");
  unmapped_a: assert property (reg_rd_i && reg_addr_i != 7'h01 |=> reg_rdata_o == 0)
    else $error("unmapped data");
  fault_or_a: assert property (reg_rvalid_o && $past(reg_addr_i) == 7'h01 |->
    $past(fault_status_o) == |(reg_rdata_o[14:0] & 15'h777c)) else $error("fault or");
  reset_out_a: assert property ($rose(nrst_i) |-> !fault_status_o && !reg_rvalid_o)
    else $error("reset out");
  uv_off_a: assert property (pump_uv_i [*7] |-> off) else $error("uv gates");
  ot_off_a: assert property (overtemp_i [*7] |-> off) else $error("ot gates");
  cover property (reg_rvalid_o && reg_rdata_o[0]);
  cover property ($fell(fault_status_o));
  cover property (pump_uv_i [*7]);
endmodule
bind gate_driver_fault_status_flags flags_asserts i_flags_asserts (.ref_clk_i, .nrst_i,
  .reg_addr_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .overtemp_i, .pump_uv_i,
  .high_side_gate_o, .low_side_gate_o, .fault_status_o);

// ### verification/host_model.sv
// Host controller model on the register port and phase inputs
`timescale 1ns/1ps
module host_model (
  input  wire logic        ref_clk_i,
  input  wire logic [31:0] rdata_i,
  output logic      [6:0]  addr_o,
  output logic             wr_o,
  output logic      [31:0] wdata_o,
  output logic             rd_o,
  output logic      [2:0]  hs_o,
  output logic      [2:0]  ls_o
);
  initial {addr_o, wr_o, wdata_o, rd_o, hs_o, ls_o} = '0;
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge ref_clk_i) #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge ref_clk_i) #1;
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [31:0] d);
    @(posedge ref_clk_i) #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge ref_clk_i) #1;
    rd_o = 1'b0;
    d = rdata_i;
  endtask
  task automatic drive(input logic [2:0] h, input logic [2:0] l);
    @(posedge ref_clk_i) #1;
    hs_o = h;
    ls_o = l;
  endtask
endmodule

// ### verification/testbench.sv
// Self-checking bench for the fault flag register
`timescale 1ns/1ps
module testbench;
  logic        ref_clk_i = 1'b0;
  logic        nrst_i, drv_en_i, wr, rd, rvalid, fault;
  logic [11:0] ev;
  logic [2:0]  hs, ls, hg, lg;
  logic [6:0]  addr;
  logic [31:0] wdata, rdata, got;
  logic [14:0] e;
  int          n_fail, n_tests;
  gate_driver_fault_status_flags i_dut (.ref_clk_i, .nrst_i, .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .drv_en_i,
    .prewarn_i(ev[0]), .overtemp_i(ev[1]), .pump_uv_i(ev[2]), .short_count_i(ev[5:3]),
    .ground_short_i(ev[8:6]), .supply_short_i(ev[11:9]), .high_side_input_i(hs),
    .low_side_input_i(ls), .high_side_gate_o(hg), .low_side_gate_o(lg), .fault_status_o(fault));
  host_model i_host (.ref_clk_i, .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .wdata_o(wdata),
    .rd_o(rd), .hs_o(hs), .ls_o(ls));
  initial forever #5 ref_clk_i = ~ref_clk_i;
  function automatic int src_bit(input int i);
    return (i < 3) ? i + 1 : 4 + (i - 3) / 3 + 4 * ((i - 3) % 3);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, g, x);
    end
  endtask
  task automatic rdc(input logic [14:0] x);
    i_host.rd(7'h01, got);
    chk(got, {17'h0, x});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i) #1;
  endtask
  task automatic finish_test;
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    nrst_i = 1'b0;
    drv_en_i = 1'b0;
    ev = 12'h000;
    n_fail = 0;
    n_tests = 0;
    void'($urandom(52467));
    tick(10);
    nrst_i = 1'b1;
    rdc(15'h0001);
    i_host.wr(7'h01, 32'h1);
    rdc(15'h0001);
    drv_en_i = 1'b1;
    tick(8);
    i_host.wr(7'h01, 32'h1);
    rdc(15'h0000);
    for (int i = 0; i < 12; i++) begin
      e = 15'h1 << src_bit(i);
      ev[i] = 1'b1;
      tick(8);
      ev[i] = 1'b0;
      tick(6);
      rdc(e);
      chk({31'h0, fault}, {31'h0, |(e & 15'h777c)});
      i_host.wr(7'h01, $urandom & ~{17'h0, e});
      rdc(e);
      i_host.wr(7'h01, {17'h0, e});
      rdc(15'h0000);
    end
    ev = 12'h042;
    tick(8);
    i_host.wr(7'h01, 32'h24);
    rdc(15'h0024);
    ev = 12'h001;
    tick(8);
    rdc(15'h0026);
    ev = 12'h000;
    drv_en_i = 1'b0;
    tick(8);
    drv_en_i = 1'b1;
    tick(8);
    rdc(15'h0002);
    i_host.drive(3'h1, 3'h0);
    ev[6] = 1'b1;
    tick(8);
    ev[6] = 1'b0;
    tick(6);
    chk({29'h0, hg}, 32'h0);
    i_host.wr(7'h01, 32'h20);
    tick(8);
    chk({29'h0, hg}, 32'h0);
    i_host.drive(3'h0, 3'h0);
    tick(6);
    i_host.drive(3'h1, 3'h0);
    tick(8);
    chk({29'h0, hg}, 32'h1);
    i_host.drive(3'h0, 3'h4);
    tick(8);
    chk({29'h0, lg}, 32'h4);
    ev[11] = 1'b1;
    tick(8);
    ev[11] = 1'b0;
    tick(6);
    chk({29'h0, lg}, 32'h0);
    rdc(15'h4002);
    chk({31'h0, fault}, 32'h1);
    i_host.wr(7'h01, 32'h4000);
    tick(8);
    chk({29'h0, lg}, 32'h0);
    i_host.drive(3'h0, 3'h0);
    tick(6);
    i_host.drive(3'h0, 3'h4);
    tick(8);
    chk({29'h0, lg}, 32'h4);
    i_host.wr(7'($urandom_range(127, 2)), 32'hffffffff);
    rdc(15'h0002);
    nrst_i = 1'b0;
    tick(2);
    nrst_i = 1'b1;
    rdc(15'h0001);
    i_host.rd(7'($urandom_range(127, 2)), got);
    finish_test();
  end
endmodule
